// ---- list_sequencer_output_control_tb.sv ----
// self-checking bench for the list sequencer and output control block
module list_sequencer_output_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic clk_en = 1'b1;
  logic local_run = 1'b0;
  logic local_step = 1'b0;
  logic [15:0] meas_amps = 16'h0000;
  logic [15:0] meas_volts = 16'h0000;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rv;
  logic reg_wr, reg_rd, supply_on_off_switch, amps_range_high, seq_active;
  logic [15:0] prog_volts, prog_amps, prog_overvolt, amps_full_scale;
  logic [5:0] seq_slot;
  int miscompares = 0;
  int cmp_count = 0;
  localparam logic [31:0] ERR_W = {15'h0000, 1'b1, lso_pkg::ERR_RANGE};

  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end

  lso_host_model host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  lso_list_seq dut (.clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .local_run(local_run), .local_step(local_step), .meas_amps(meas_amps),
    .meas_volts(meas_volts), .prog_volts(prog_volts), .prog_amps(prog_amps),
    .prog_overvolt(prog_overvolt), .supply_on_off_switch(supply_on_off_switch),
    .amps_range_high(amps_range_high), .amps_full_scale(amps_full_scale),
    .seq_active(seq_active), .seq_slot(seq_slot));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    host.rd(a, rv);
    chk(what, rv, exp);
  endtask : rchk
  task automatic pulse(input logic step);
    @(posedge clk_sys);
    local_run <= !step;
    local_step <= step;
    @(posedge clk_sys);
    local_run <= 1'b0;
    local_step <= 1'b0;
    #1;
  endtask : pulse
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rchk("ctrl", lso_pkg::OFS_CTRL, 32'h0000_0003);
    rchk("amps max", lso_pkg::OFS_AMPS_MAX, {16'h0000, lso_pkg::AMPS_MAX});
    rchk("amps min", lso_pkg::OFS_AMPS_MIN, 32'h0000_0000);
    rchk("first", lso_pkg::OFS_FIRST_SLOT, 32'h0000_0001);
    rchk("pointer", lso_pkg::OFS_SLOT_PTR, 32'h0000_0001);
  endtask : t_reset
  // slots 1, 2 and the last one; chain 2 -> 40 -> 1 -> end
  task automatic t_list;
    logic [5:0] s [3] = '{6'h01, 6'h02, 6'h28};
    logic [5:0] n [3] = '{6'h00, 6'h28, 6'h01};
    for (int i = 0; i < 3; i++) begin
      host.slot_wr(s[i], lso_pkg::OFS_SLOT_VOLTS, 32'h0000_1000 + s[i]);
      host.wr(lso_pkg::OFS_SLOT_OVERVOLT, 32'h0000_2000 + s[i]);
      host.wr(lso_pkg::OFS_SLOT_SUCC, {26'h000_0000, n[i]});
    end
    for (int i = 0; i < 3; i++) begin
      host.wr(lso_pkg::OFS_SLOT_PTR, {26'h000_0000, s[i]});
      rchk("slot volts", lso_pkg::OFS_SLOT_VOLTS, 32'h0000_1000 + s[i]);
      rchk("slot ovp", lso_pkg::OFS_SLOT_OVERVOLT, 32'h0000_2000 + s[i]);
      rchk("successor", lso_pkg::OFS_SLOT_SUCC, {26'h000_0000, n[i]});
    end
    // pointer is left on the last slot here
    host.wr(lso_pkg::OFS_SLOT_VOLTS, 32'h0001_0000);
    rchk("volts error", lso_pkg::OFS_ERROR, ERR_W);
    rchk("error cleared", lso_pkg::OFS_ERROR, 32'h0000_0000);
    host.wr(lso_pkg::OFS_SLOT_OVERVOLT, 32'h0002_0000);
    rchk("ovp error", lso_pkg::OFS_ERROR, ERR_W);
    rchk("volts kept", lso_pkg::OFS_SLOT_VOLTS, 32'h0000_1028);
    rchk("ovp kept", lso_pkg::OFS_SLOT_OVERVOLT, 32'h0000_2028);
  endtask : t_list
  task automatic t_bad;
    host.wr(lso_pkg::OFS_SLOT_SUCC, 32'h0000_0029);
    rchk("succ error", lso_pkg::OFS_ERROR, ERR_W);
    rchk("succ kept", lso_pkg::OFS_SLOT_SUCC, 32'h0000_0001);
    host.wr(lso_pkg::OFS_FIRST_SLOT, 32'h0000_0000);
    rchk("first error", lso_pkg::OFS_ERROR, ERR_W);
    rchk("first kept", lso_pkg::OFS_FIRST_SLOT, 32'h0000_0001);
    host.wr(lso_pkg::OFS_SLOT_PTR, 32'h0000_0029);
    rchk("ptr error", lso_pkg::OFS_ERROR, ERR_W);
    rchk("ptr kept", lso_pkg::OFS_SLOT_PTR, 32'h0000_0028);
  endtask : t_bad
  task automatic t_seq;
    logic [5:0] s [3] = '{6'h02, 6'h28, 6'h01};
    host.wr(lso_pkg::OFS_FIRST_SLOT, 32'h0000_0002);
    rchk("first", lso_pkg::OFS_FIRST_SLOT, 32'h0000_0002);
    pulse(1'b0);
    for (int i = 0; i < 3; i++) begin
      chk("active", {31'h0, seq_active}, 32'h0000_0001);
      chk("slot", {26'h0, seq_slot}, {26'h0, s[i]});
      chk("slot ovp out", {16'h0, prog_overvolt}, 32'h0000_2000 + s[i]);
      pulse(1'b1);
    end
    chk("chain end", {31'h0, seq_active}, 32'h0000_0000);
  endtask : t_seq
  task automatic t_out;
    host.wr(lso_pkg::OFS_VOLTS_SET, 32'h0000_1234);
    host.wr(lso_pkg::OFS_AMPS_SET, 32'h0000_0056);
    host.wr(lso_pkg::OFS_CTRL, 32'h0000_0000);
    chk("off volts", {16'h0, prog_volts}, 32'h0000_0000);
    chk("off amps", {16'h0, prog_amps}, 32'h0000_0000);
    chk("low scale", {16'h0, amps_full_scale}, 32'h0000_1999);
    rchk("ctrl off", lso_pkg::OFS_CTRL, 32'h0000_0000);
    rchk("saved volts", lso_pkg::OFS_VOLTS_SET, 32'h0000_1234);
    rchk("saved amps", lso_pkg::OFS_AMPS_SET, 32'h0000_0056);
    host.wr(lso_pkg::OFS_CTRL, 32'h0000_0003);
    chk("on volts", {16'h0, prog_volts}, 32'h0000_1234);
    chk("on amps", {16'h0, prog_amps}, 32'h0000_0056);
    chk("high scale", {16'h0, amps_full_scale}, {16'h0, lso_pkg::AMPS_MAX});
  endtask : t_out
  task automatic t_clamp;
    host.wr(lso_pkg::OFS_AMPS_CLAMP, 32'h0000_0100);
    host.wr(lso_pkg::OFS_AMPS_SET, 32'h0000_0200);
    chk("clamped out", {16'h0, prog_amps}, 32'h0000_0100);
    host.wr(lso_pkg::OFS_AMPS_SET, 32'h0001_0000);
    rchk("amps error", lso_pkg::OFS_ERROR, ERR_W);
    rchk("amps kept", lso_pkg::OFS_AMPS_SET, 32'h0000_0100);
    rchk("clamp", lso_pkg::OFS_AMPS_CLAMP, 32'h0000_0100);
  endtask : t_clamp
  // register run, step and stop; frozen bus; list kept through a reset
  task automatic t_ctrl;
    host.wr(lso_pkg::OFS_CTRL, 32'h0000_0007);
    chk("run volts", {16'h0, prog_volts}, 32'h0000_1002);
    rchk("run stat", lso_pkg::OFS_SEQ_STAT, 32'h0000_0102);
    host.wr(lso_pkg::OFS_CTRL, 32'h0000_000b);
    rchk("step stat", lso_pkg::OFS_SEQ_STAT, 32'h0000_0128);
    host.wr(lso_pkg::OFS_CTRL, 32'h0000_0013);
    rchk("stop stat", lso_pkg::OFS_SEQ_STAT, 32'h0000_0028);
    @(posedge clk_sys);
    clk_en <= 1'b0;
    host.wr(lso_pkg::OFS_CTRL, 32'h0000_0000);
    chk("frozen", {30'h0, amps_range_high, supply_on_off_switch}, 32'h0000_0003);
    @(posedge clk_sys);
    clk_en <= 1'b1;
    host.wr(lso_pkg::OFS_CTRL, 32'h0000_0000);
    chk("off", {30'h0, amps_range_high, supply_on_off_switch}, 32'h0000_0000);
    @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    rchk("ctrl reset", lso_pkg::OFS_CTRL, 32'h0000_0003);
    host.wr(lso_pkg::OFS_SLOT_PTR, 32'h0000_0002);
    rchk("kept volts", lso_pkg::OFS_SLOT_VOLTS, 32'h0000_1002);
    rchk("kept succ", lso_pkg::OFS_SLOT_SUCC, 32'h0000_0028);
  endtask : t_ctrl
  task automatic t_meas;
    @(posedge clk_sys);
    meas_amps <= 16'h0abc;
    meas_volts <= 16'h0def;
    repeat (4) @(posedge clk_sys);
    rchk("meas amps", lso_pkg::OFS_MEAS_AMPS, 32'h0000_0abc);
    rchk("quest clear", lso_pkg::OFS_QUEST, 32'h0000_0000);
    rchk("meas amps sfx", lso_pkg::OFS_MEAS_AMPS_X, 32'h0000_0abc);
    rchk("quest set", lso_pkg::OFS_QUEST, 32'h0000_2000);
    host.wr(lso_pkg::OFS_QUEST, 32'h0000_2000);
    rchk("meas volts", lso_pkg::OFS_MEAS_VOLTS, 32'h0000_0def);
    rchk("quest cleared", lso_pkg::OFS_QUEST, 32'h0000_0000);
    rchk("meas volts sfx", lso_pkg::OFS_MEAS_VOLTS_X, 32'h0000_0def);
    rchk("quest again", lso_pkg::OFS_QUEST, 32'h0000_2000);
  endtask : t_meas

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    t_reset();
    t_list();
    t_bad();
    t_seq();
    t_out();
    t_clamp();
    t_ctrl();
    t_meas();
    end_of_test();
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    end_of_test();
  end
endmodule : list_sequencer_output_control_tb

// ---- lso_host_model.sv ----
// remote host model: drives the register port like the bus controller
module lso_host_model (
  // clock
  input wire logic clk_sys,
  // register port
  output logic [lso_pkg::ADDR_W-1:0] reg_addr,
  output logic [lso_pkg::DATA_W-1:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [lso_pkg::DATA_W-1:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // idle address and data show the inverse, never a stale copy
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask : rd
  // pointer always set before a per-slot field
  task automatic slot_wr(input logic [5:0] s, input logic [7:0] a, input logic [31:0] d);
    wr(lso_pkg::OFS_SLOT_PTR, {26'h000_0000, s});
    wr(a, d);
  endtask : slot_wr
endmodule : lso_host_model

// ---- lso_list_seq.sv ----
// list memory, sequencer and output control of a programmable dc source
module lso_list_seq (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clk_en,
  // register port
  input wire logic [lso_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [lso_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [lso_pkg::DATA_W-1:0] reg_rdata,
  // local front panel controls, same clock
  input wire logic local_run,
  input wire logic local_step,
  // converter readback, asynchronous
  input wire logic [lso_pkg::VAL_W-1:0] meas_amps,
  input wire logic [lso_pkg::VAL_W-1:0] meas_volts,
  // analog loop programming
  output logic [lso_pkg::VAL_W-1:0] prog_volts,
  output logic [lso_pkg::VAL_W-1:0] prog_amps,
  output logic [lso_pkg::VAL_W-1:0] prog_overvolt,
  output logic supply_on_off_switch,
  output logic amps_range_high,
  output logic [lso_pkg::VAL_W-1:0] amps_full_scale,
  output logic seq_active,
  output logic [lso_pkg::SLOT_W-1:0] seq_slot
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [lso_pkg::VAL_W-1:0] slot_volts_value [0:lso_pkg::SLOT_COUNT-1];
  logic [lso_pkg::VAL_W-1:0] slot_overvolt_value [0:lso_pkg::SLOT_COUNT-1];
  logic [lso_pkg::SLOT_W-1:0] slot_successor_number [0:lso_pkg::SLOT_COUNT-1];
  logic [lso_pkg::SLOT_W-1:0] list_slot_pointer_q;
  logic [lso_pkg::SLOT_W-1:0] program_first_slot_q;
  logic [lso_pkg::VAL_W-1:0] volts_set_q;
  logic [lso_pkg::VAL_W-1:0] amps_setpoint_q;
  logic [lso_pkg::VAL_W-1:0] amps_upper_clamp_q;
  logic out_on_q;
  logic range_high_q;
  logic quest_warn_q;
  logic err_pend_q;
  logic [lso_pkg::VAL_W-1:0] err_code_q;
  logic [lso_pkg::DATA_W-1:0] rdata_q;
  logic [lso_pkg::DATA_W-1:0] rdata_d;
  lso_pkg::lso_seq_t seq_state_q;
  lso_pkg::lso_seq_t seq_state_d;
  logic [lso_pkg::SLOT_W-1:0] seq_slot_q;
  logic [lso_pkg::SLOT_W-1:0] seq_slot_d;
  logic [lso_pkg::VAL_W-1:0] meas_amps_s1_q;
  logic [lso_pkg::VAL_W-1:0] meas_amps_s2_q;
  logic [lso_pkg::VAL_W-1:0] meas_volts_s1_q;
  logic [lso_pkg::VAL_W-1:0] meas_volts_s2_q;

  ////////////////////////////////////////////////////////////////////////////
  // decode
  wire wr_ok = reg_wr && clk_en;
  wire rd_ok = reg_rd && clk_en;
  wire wr_ctrl = wr_ok && (reg_addr == lso_pkg::OFS_CTRL);
  wire wr_ptr = wr_ok && (reg_addr == lso_pkg::OFS_SLOT_PTR);
  wire wr_svolt = wr_ok && (reg_addr == lso_pkg::OFS_SLOT_VOLTS);
  wire wr_sover = wr_ok && (reg_addr == lso_pkg::OFS_SLOT_OVERVOLT);
  wire wr_succ = wr_ok && (reg_addr == lso_pkg::OFS_SLOT_SUCC);
  wire wr_first = wr_ok && (reg_addr == lso_pkg::OFS_FIRST_SLOT);
  wire wr_vset = wr_ok && (reg_addr == lso_pkg::OFS_VOLTS_SET);
  wire wr_aset = wr_ok && (reg_addr == lso_pkg::OFS_AMPS_SET);
  wire wr_clamp = wr_ok && (reg_addr == lso_pkg::OFS_AMPS_CLAMP);
  wire wr_quest = wr_ok && (reg_addr == lso_pkg::OFS_QUEST);
  wire rd_err = rd_ok && (reg_addr == lso_pkg::OFS_ERROR);
  wire rd_meas_x = rd_ok && ((reg_addr == lso_pkg::OFS_MEAS_AMPS_X) ||
                             (reg_addr == lso_pkg::OFS_MEAS_VOLTS_X));

  // value checks; upper bits of the write word must be clear too
  wire [lso_pkg::VAL_W-1:0] wval = reg_wdata[lso_pkg::VAL_W-1:0];
  wire hi_clear = (reg_wdata[lso_pkg::DATA_W-1:lso_pkg::VAL_W] == '0);
  wire [lso_pkg::SLOT_W-1:0] wslot = reg_wdata[lso_pkg::SLOT_W-1:0];
  wire slot_hi_clear = (reg_wdata[lso_pkg::DATA_W-1:lso_pkg::SLOT_W] == '0);
  wire slot_in = slot_hi_clear && (wslot >= lso_pkg::SLOT_FIRST) && (wslot <= lso_pkg::SLOT_LAST);
  wire succ_in = slot_hi_clear && (wslot <= lso_pkg::SLOT_LAST);
  wire volts_in = hi_clear && (wval <= lso_pkg::VOLTS_MAX);
  wire amps_in = hi_clear && (wval <= lso_pkg::AMPS_MAX);
  wire [lso_pkg::VAL_W-1:0] amps_clamped =
    (wval > amps_upper_clamp_q) ? amps_upper_clamp_q : wval;

  wire bad_write = (wr_ptr && !slot_in) ||
                   (wr_first && !slot_in) ||
                   (wr_succ && !succ_in) ||
                   (wr_svolt && !volts_in) ||
                   (wr_sover && !volts_in) ||
                   (wr_vset && !volts_in) ||
                   (wr_aset && !amps_in) ||
                   (wr_clamp && !amps_in);

  // the host owns slot pointer placement before slot access
  wire [lso_pkg::SLOT_W-1:0] ptr = list_slot_pointer_q;

  ////////////////////////////////////////////////////////////////////////////
  // list memory: no reset so contents ride through a warm reset
  always_ff @(posedge clk_sys) begin
    if (wr_svolt && volts_in) begin
      slot_volts_value[ptr] <= wval;
    end
    if (wr_sover && volts_in) begin
      slot_overvolt_value[ptr] <= wval;
    end
    if (wr_succ && succ_in) begin
      slot_successor_number[ptr] <= wslot;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pointers and setpoints
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      list_slot_pointer_q <= lso_pkg::SLOT_FIRST;
      program_first_slot_q <= lso_pkg::SLOT_FIRST;
    end else begin
      if (wr_ptr && slot_in) begin
        list_slot_pointer_q <= wslot;
      end
      if (wr_first && slot_in) begin
        program_first_slot_q <= wslot;
      end
    end
  end

  // setpoints stay in place while off, so they are the saved copy
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      volts_set_q <= '0;
      amps_setpoint_q <= '0;
      amps_upper_clamp_q <= lso_pkg::AMPS_MAX;
    end else begin
      if (wr_vset && volts_in) begin
        volts_set_q <= wval;
      end
      if (wr_aset && amps_in) begin
        amps_setpoint_q <= amps_clamped;
      end
      if (wr_clamp && amps_in) begin
        amps_upper_clamp_q <= wval;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      out_on_q <= lso_pkg::RST_OUT_ON;
      range_high_q <= lso_pkg::RST_RANGE_HIGH;
    end else if (wr_ctrl) begin
      out_on_q <= reg_wdata[lso_pkg::CTRL_OUT_ON];
      range_high_q <= reg_wdata[lso_pkg::CTRL_RANGE_HIGH];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status: set wins over clear on both flags
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      quest_warn_q <= 1'b0;
      err_pend_q <= 1'b0;
      err_code_q <= lso_pkg::ERR_NONE;
    end else begin
      if (rd_meas_x) begin
        quest_warn_q <= 1'b1;
      end else if (wr_quest && reg_wdata[lso_pkg::QUEST_CMD_WARN]) begin
        quest_warn_q <= 1'b0;
      end
      if (bad_write) begin
        err_pend_q <= 1'b1;
        err_code_q <= lso_pkg::ERR_RANGE;
      end else if (rd_err) begin
        err_pend_q <= 1'b0;
        err_code_q <= lso_pkg::ERR_NONE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer: run or step enters at the first slot, step walks the chain
  wire [lso_pkg::SLOT_W-1:0] succ_now = slot_successor_number[seq_slot_q];
  wire run_req = local_run || (wr_ctrl && reg_wdata[lso_pkg::CTRL_RUN]);
  wire step_req = local_step || (wr_ctrl && reg_wdata[lso_pkg::CTRL_STEP]);
  wire stop_req = wr_ctrl && reg_wdata[lso_pkg::CTRL_STOP];

  always_comb begin
    seq_state_d = seq_state_q;
    seq_slot_d = seq_slot_q;
    case (seq_state_q)
      lso_pkg::SEQ_IDLE: begin
        if (run_req || step_req) begin
          seq_state_d = lso_pkg::SEQ_RUN;
          seq_slot_d = program_first_slot_q;
        end
      end
      lso_pkg::SEQ_RUN: begin
        if (stop_req) begin
          seq_state_d = lso_pkg::SEQ_IDLE;
        end else if (step_req) begin
          if (succ_now == lso_pkg::SLOT_END) begin
            seq_state_d = lso_pkg::SEQ_IDLE;
          end else begin
            seq_slot_d = succ_now;
          end
        end
      end
      default: begin
        seq_state_d = lso_pkg::SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      seq_state_q <= lso_pkg::SEQ_IDLE;
      seq_slot_q <= lso_pkg::SLOT_FIRST;
    end else if (clk_en) begin
      seq_state_q <= seq_state_d;
      seq_slot_q <= seq_slot_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // measurement synchronisers; a moving multi-bit value may tear for one
  // sample, acceptable because the converter updates far slower than clk_sys
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      meas_amps_s1_q <= '0;
      meas_amps_s2_q <= '0;
      meas_volts_s1_q <= '0;
      meas_volts_s2_q <= '0;
    end else if (clk_en) begin
      meas_amps_s1_q <= meas_amps;
      meas_amps_s2_q <= meas_amps_s1_q;
      meas_volts_s1_q <= meas_volts;
      meas_volts_s2_q <= meas_volts_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux
  always_comb begin
    rdata_d = '0;
    case (reg_addr)
      lso_pkg::OFS_CTRL: begin
        rdata_d[lso_pkg::CTRL_OUT_ON] = out_on_q;
        rdata_d[lso_pkg::CTRL_RANGE_HIGH] = range_high_q;
      end
      lso_pkg::OFS_SLOT_PTR: rdata_d[lso_pkg::SLOT_W-1:0] = ptr;
      lso_pkg::OFS_SLOT_VOLTS: rdata_d[lso_pkg::VAL_W-1:0] = slot_volts_value[ptr];
      lso_pkg::OFS_SLOT_OVERVOLT: begin
        rdata_d[lso_pkg::VAL_W-1:0] = slot_overvolt_value[ptr];
      end
      lso_pkg::OFS_SLOT_SUCC: begin
        rdata_d[lso_pkg::SLOT_W-1:0] = slot_successor_number[ptr];
      end
      lso_pkg::OFS_FIRST_SLOT: rdata_d[lso_pkg::SLOT_W-1:0] = program_first_slot_q;
      lso_pkg::OFS_VOLTS_SET: rdata_d[lso_pkg::VAL_W-1:0] = volts_set_q;
      lso_pkg::OFS_AMPS_SET: rdata_d[lso_pkg::VAL_W-1:0] = amps_setpoint_q;
      lso_pkg::OFS_AMPS_CLAMP: rdata_d[lso_pkg::VAL_W-1:0] = amps_upper_clamp_q;
      lso_pkg::OFS_AMPS_MAX: rdata_d[lso_pkg::VAL_W-1:0] = lso_pkg::AMPS_MAX;
      lso_pkg::OFS_AMPS_MIN: rdata_d[lso_pkg::VAL_W-1:0] = lso_pkg::AMPS_MIN;
      lso_pkg::OFS_MEAS_AMPS, lso_pkg::OFS_MEAS_AMPS_X: begin
        rdata_d[lso_pkg::VAL_W-1:0] = meas_amps_s2_q;
      end
      lso_pkg::OFS_MEAS_VOLTS, lso_pkg::OFS_MEAS_VOLTS_X: begin
        rdata_d[lso_pkg::VAL_W-1:0] = meas_volts_s2_q;
      end
      lso_pkg::OFS_QUEST: rdata_d[lso_pkg::QUEST_CMD_WARN] = quest_warn_q;
      lso_pkg::OFS_ERROR: begin
        rdata_d[lso_pkg::ERR_PENDING] = err_pend_q;
        rdata_d[lso_pkg::VAL_W-1:0] = err_code_q;
      end
      lso_pkg::OFS_SEQ_STAT: begin
        rdata_d[lso_pkg::STAT_ACTIVE] = (seq_state_q == lso_pkg::SEQ_RUN);
        rdata_d[lso_pkg::SLOT_W-1:0] = seq_slot_q;
      end
      default: rdata_d = '0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= '0;
    end else if (rd_ok) begin
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs: while a sequence runs the list drives volts and overvolt; amps stay on the setpoint
  wire seq_on = (seq_state_q == lso_pkg::SEQ_RUN);
  wire [lso_pkg::VAL_W-1:0] volts_src = seq_on ? slot_volts_value[seq_slot_q] : volts_set_q;
  wire [lso_pkg::VAL_W-1:0] over_src =
    seq_on ? slot_overvolt_value[seq_slot_q] : lso_pkg::VOLTS_MAX;

  assign reg_rdata = rdata_q;
  assign prog_volts = out_on_q ? volts_src : '0;
  assign prog_amps = out_on_q ? amps_setpoint_q : '0;
  assign prog_overvolt = over_src;
  assign supply_on_off_switch = out_on_q;
  assign amps_range_high = range_high_q;
  assign amps_full_scale = range_high_q ? lso_pkg::AMPS_MAX :
                           (lso_pkg::AMPS_MAX / lso_pkg::AMPS_LOW_DIV);
  assign seq_active = seq_on;
  assign seq_slot = seq_slot_q;

endmodule : lso_list_seq

// ---- lso_list_seq_checker.sv ----
// concurrent checks on the ports of the list sequencer block
module lso_list_seq_checker (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clk_en,
  // register port
  input wire logic [lso_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [lso_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [lso_pkg::DATA_W-1:0] reg_rdata,
  // local control
  input wire logic local_run,
  // loop programming
  input wire logic [lso_pkg::VAL_W-1:0] prog_volts,
  input wire logic [lso_pkg::VAL_W-1:0] prog_amps,
  input wire logic supply_on_off_switch,
  input wire logic amps_range_high,
  input wire logic [lso_pkg::VAL_W-1:0] amps_full_scale,
  input wire logic seq_active,
  input wire logic [lso_pkg::SLOT_W-1:0] seq_slot
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic ctrl_wr = clk_en && reg_wr && (reg_addr == lso_pkg::OFS_CTRL);
  wire logic ctrl_rd = clk_en && reg_rd && (reg_addr == lso_pkg::OFS_CTRL);
  wire logic wd_on = reg_wdata[lso_pkg::CTRL_OUT_ON];
  wire logic wd_high = reg_wdata[lso_pkg::CTRL_RANGE_HIGH];
  wire logic wd_stop = reg_wdata[lso_pkg::CTRL_STOP];

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  ////////////////////////////////////////////////////////////////////////////
  chk_off_volts_zero: assert property (!supply_on_off_switch |-> prog_volts == '0)
    else $error("programmed volts not zero while output off");
  chk_off_amps_zero: assert property (!supply_on_off_switch |-> prog_amps == '0)
    else $error("programmed amps not zero while output off");
  chk_switch_follows: assert property (
    ctrl_wr |=> supply_on_off_switch == $past(wd_on))
    else $error("output switch did not follow control write");
  chk_range_follows: assert property (ctrl_wr |=> amps_range_high == $past(wd_high))
    else $error("range select did not follow control write");
  chk_scale_full: assert property (
    amps_range_high |-> amps_full_scale == lso_pkg::AMPS_MAX)
    else $error("high scale not full model maximum");
  chk_scale_tenth: assert property (
    !amps_range_high |-> amps_full_scale == lso_pkg::AMPS_MAX / lso_pkg::AMPS_LOW_DIV)
    else $error("low scale not a tenth of maximum");
  chk_state_read: assert property (
    ctrl_rd |=> reg_rdata[0] == $past(supply_on_off_switch)
    && reg_rdata[1] == $past(amps_range_high))
    else $error("control read disagrees with output state");
  chk_reset_output_on: assert property ($rose(resetn) |-> supply_on_off_switch)
    else $error("output not enabled after reset");
  chk_run_starts: assert property (
    clk_en && local_run && !(ctrl_wr && wd_stop) |=> seq_active)
    else $error("run pulse did not start the sequence");
  chk_slot_bounds: assert property (
    seq_active |-> seq_slot >= lso_pkg::SLOT_FIRST && seq_slot <= lso_pkg::SLOT_LAST)
    else $error("running slot outside 1 to 40");
endmodule : lso_list_seq_checker

bind lso_list_seq lso_list_seq_checker u_chk (.clk_sys(clk_sys), .resetn(resetn),
  .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .local_run(local_run), .prog_volts(prog_volts),
  .prog_amps(prog_amps), .supply_on_off_switch(supply_on_off_switch),
  .amps_range_high(amps_range_high), .amps_full_scale(amps_full_scale),
  .seq_active(seq_active), .seq_slot(seq_slot));

// ---- lso_pkg.sv ----
// constants for the list sequencer and output control block
package lso_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // bus and value widths
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned VAL_W = 16;
  localparam int unsigned SLOT_W = 6;

  ////////////////////////////////////////////////////////////////////////////
  // list geometry
  localparam logic [5:0] SLOT_FIRST = 6'h01;
  localparam logic [5:0] SLOT_LAST = 6'h28;
  localparam logic [5:0] SLOT_END = 6'h00;
  localparam int unsigned SLOT_COUNT = 41;

  ////////////////////////////////////////////////////////////////////////////
  // model limits in converter lsb units
  localparam logic [15:0] VOLTS_MAX = 16'hFFFF;
  localparam logic [15:0] AMPS_MAX = 16'hFFFF;
  localparam logic [15:0] AMPS_MIN = 16'h0000;
  localparam logic [15:0] AMPS_LOW_DIV = 16'h000A;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SLOT_PTR = 8'h04;
  localparam logic [7:0] OFS_SLOT_VOLTS = 8'h08;
  localparam logic [7:0] OFS_SLOT_OVERVOLT = 8'h0C;
  localparam logic [7:0] OFS_SLOT_SUCC = 8'h10;
  localparam logic [7:0] OFS_FIRST_SLOT = 8'h14;
  localparam logic [7:0] OFS_VOLTS_SET = 8'h18;
  localparam logic [7:0] OFS_AMPS_SET = 8'h1C;
  localparam logic [7:0] OFS_AMPS_CLAMP = 8'h20;
  localparam logic [7:0] OFS_AMPS_MAX = 8'h24;
  localparam logic [7:0] OFS_AMPS_MIN = 8'h28;
  localparam logic [7:0] OFS_MEAS_AMPS = 8'h30;
  localparam logic [7:0] OFS_MEAS_VOLTS = 8'h34;
  localparam logic [7:0] OFS_MEAS_AMPS_X = 8'h38;
  localparam logic [7:0] OFS_MEAS_VOLTS_X = 8'h3C;
  localparam logic [7:0] OFS_QUEST = 8'h40;
  localparam logic [7:0] OFS_ERROR = 8'h44;
  localparam logic [7:0] OFS_SEQ_STAT = 8'h48;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int unsigned CTRL_OUT_ON = 0;
  localparam int unsigned CTRL_RANGE_HIGH = 1;
  localparam int unsigned CTRL_RUN = 2;
  localparam int unsigned CTRL_STEP = 3;
  localparam int unsigned CTRL_STOP = 4;
  localparam int unsigned QUEST_CMD_WARN = 13;
  localparam int unsigned ERR_PENDING = 16;
  localparam int unsigned STAT_ACTIVE = 8;

  ////////////////////////////////////////////////////////////////////////////
  // reset values and codes
  localparam logic RST_OUT_ON = 1'b1;
  localparam logic RST_RANGE_HIGH = 1'b1;
  localparam logic [15:0] ERR_RANGE = 16'hFF22;
  localparam logic [15:0] ERR_NONE = 16'h0000;

  typedef enum logic {SEQ_IDLE, SEQ_RUN} lso_seq_t;

endpackage : lso_pkg
